// >>> src/frq_cfg.svh
// Constants of the frequency protection block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef FRQ_CFG_SVH
`define FRQ_CFG_SVH
// Register byte offsets
`define FRQ_CTRL 8'h00
`define FRQ_STG_EN 8'h04
`define FRQ_FORCE 8'h08
`define FRQ_EVMASK 8'h0c
`define FRQ_UVLVL 8'h10
`define FRQ_RELTIME 8'h14
`define FRQ_PSEL 8'h18
`define FRQ_PLEVEL 8'h1c
`define FRQ_PDELAY 8'h20
`define FRQ_STATUS 8'h24
`define FRQ_RATIO 8'h28
`define FRQ_EXPECT 8'h2c
`define FRQ_REMAIN 8'h30
`define FRQ_CNT_S 8'h34
`define FRQ_CNT_T 8'h38
`define FRQ_CNT_B 8'h3c
`define FRQ_REC_SEL 8'h40
`define FRQ_REC_TIME 8'h44
`define FRQ_REC_INFO 8'h48
`define FRQ_REC_FREQ 8'h4c
// Field positions
`define FRQ_CTRL_FORCE 2
`define FRQ_CTRL_GROUP 3
`define FRQ_CTRL_RELEN 4
`define FRQ_CTRL_CLR 5
`define FRQ_PLEVEL_INUSE 16
// Reset values
`define FRQ_REFSEL_RST 2'h0
`define FRQ_RELEN_RST 1'h1
`define FRQ_EVMASK_RST 6'h3f
`define FRQ_OVER_RST 16'h13ec
`define FRQ_UNDER_RST 16'h1324
// Timing
`define FRQ_CLK_NS 5
`define FRQ_TICK_NS 5000000
`define FRQ_TICK_CYC (`FRQ_TICK_NS / `FRQ_CLK_NS)
`define FRQ_TICK_MS 5
`define FRQ_REL_MS 60
`define FRQ_DLY_MS 40
`define FRQ_PRE_MS 20
`define FRQ_PRE_TICKS (`FRQ_PRE_MS / `FRQ_TICK_MS)
`define FRQ_HYST_MHZ 20
`define FRQ_STEP_MHZ 10
`define FRQ_HYST (`FRQ_HYST_MHZ / `FRQ_STEP_MHZ)
`define FRQ_RATIO_SCALE 26'h00003e8
`define FRQ_NREC 12
`define FRQ_DIV_BITS 5'h1a
`endif

// >>> src/frq_pkg.sv
// Types shared by the frequency protection block.
// Assumes frq_cfg.svh is on the include path.
package frq_pkg;
  typedef enum logic [1:0] {
    FRQ_NORMAL = 2'b00,
    FRQ_START = 2'b01,
    FRQ_TRIP = 2'b10,
    FRQ_BLOCKED = 2'b11
  } frq_cond_type;
  typedef logic [15:0] frq_freq_type;
  typedef logic [18:0] frq_ticks_type;
  typedef struct packed {
    frq_freq_type f1;
    frq_freq_type f2;
    frq_freq_type f3;
    logic [15:0] volt;
    logic block;
  } frq_meas_type;
  typedef struct packed {
    logic in_use;
    frq_freq_type level;
    frq_ticks_type delay;
  } frq_param_type;
  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0] stage;
    logic [1:0] kind;
    logic on;
  } frq_event_type;
endpackage

// >>> src/frq_stage.sv
// One frequency stage: pick-up with hysteresis, blocking, definite time.
// Assumes tick marks one 5 ms processing cycle with inputs already sampled.
`timescale 1ns/100ps
`include "frq_cfg.svh"
module frq_stage #(
  parameter bit UNDER = 1'b0
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  // Settings
  input wire logic active,
  input wire logic force_on,
  input wire frq_pkg::frq_cond_type force_val,
  input wire frq_pkg::frq_param_type prm,
  input wire frq_pkg::frq_ticks_type rel_time,
  input wire logic rel_en,
  // Sampled measurement
  input wire frq_pkg::frq_freq_type freq,
  input wire logic uv_blk,
  input wire logic blk_in,
  // Results
  output logic start,
  output logic trip,
  output logic blocked,
  output frq_pkg::frq_ticks_type remain
);
  import frq_pkg::*;
  logic picked, st, tr, bl, raw, pu, hold;
  logic [16:0] f17, lv17;
  frq_ticks_type cnt, cnt_n, rcnt;

  assign f17 = {1'b0, freq};
  assign lv17 = {1'b0, prm.level};
  always_comb begin
    if (UNDER)
      raw = picked ? (f17 < lv17 + 17'(`FRQ_HYST)) : (f17 < lv17);
    else
      raw = picked ? (f17 + 17'(`FRQ_HYST) > lv17) : (f17 > lv17);
  end
  assign pu = active && raw && !(UNDER && uv_blk);
  assign cnt_n = (cnt >= prm.delay) ? cnt : cnt + 19'h00001;
  assign hold = st && rel_en && !pu && (rcnt < rel_time);
  assign remain = (cnt < prm.delay) ? prm.delay - cnt : 19'h00000;

  always_ff @(posedge clk) begin
    if (rst) begin
      picked <= 1'b0;
      st <= 1'b0;
      tr <= 1'b0;
      bl <= 1'b0;
      cnt <= 19'h00000;
      rcnt <= 19'h00000;
    end else if (ce && tick) begin
      picked <= active && raw;
      if (!active) begin
        st <= 1'b0;
        tr <= 1'b0;
        bl <= 1'b0;
        cnt <= 19'h00000;
        rcnt <= 19'h00000;
      end else if (pu && !blk_in) begin
        st <= 1'b1;
        bl <= 1'b0;
        rcnt <= 19'h00000;
        cnt <= cnt_n;
        if (cnt_n >= prm.delay)
          tr <= 1'b1;
      end else begin
        bl <= pu;
        if (hold) begin
          rcnt <= rcnt + 19'h00001;
        end else begin
          st <= 1'b0;
          tr <= 1'b0;
          if (!rel_en || rcnt >= rel_time)
            cnt <= 19'h00000;
          else
            rcnt <= rcnt + 19'h00001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
    end else if (ce) begin
      if (force_on) begin
        start <= force_val == FRQ_START;
        trip <= force_val == FRQ_TRIP;
        blocked <= force_val == FRQ_BLOCKED;
      end else begin
        start <= st;
        trip <= tr;
        blocked <= bl;
      end
    end
  end
endmodule

// >>> src/frq_div.sv
// Serial divider for the measured-to-set frequency ratio.
// Assumes go is a one-cycle pulse; the result saturates to 16 bits.
`timescale 1ns/100ps
`include "frq_cfg.svh"
module frq_div (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic go,
  // Operands and result
  input wire logic [25:0] num,
  input wire logic [15:0] den,
  output logic [15:0] quo
);
  import frq_pkg::*;
  typedef enum logic [0:0] {FRQ_DIV_IDLE = 1'b0, FRQ_DIV_RUN = 1'b1} frq_div_type;
  frq_div_type state;
  logic [4:0] bits;
  logic [25:0] q;
  logic [16:0] rem, r;

  assign r = {rem[15:0], q[25]};
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FRQ_DIV_IDLE;
      bits <= 5'h00;
      q <= 26'h0000000;
      rem <= 17'h00000;
      quo <= 16'h0000;
    end else if (ce) begin
      case (state)
        FRQ_DIV_IDLE: begin
          if (go) begin
            q <= num;
            rem <= 17'h00000;
            bits <= `FRQ_DIV_BITS;
            state <= FRQ_DIV_RUN;
          end
        end
        FRQ_DIV_RUN: begin
          if (r >= {1'b0, den}) begin
            rem <= r - {1'b0, den};
            q <= {q[24:0], 1'b1};
          end else begin
            rem <= r;
            q <= {q[24:0], 1'b0};
          end
          bits <= bits - 5'h01;
          if (bits == 5'h01)
            state <= FRQ_DIV_IDLE;
        end
        default: state <= FRQ_DIV_IDLE;
      endcase
      if (state == FRQ_DIV_IDLE && bits == 5'h00)
        quo <= (|q[25:16]) ? 16'hffff : q[15:0];
    end
  end
endmodule

// >>> src/frq_prot.sv
// Four over- and four underfrequency stages with APB registers,
// events, counters and a twelve-entry fault record.
// Assumes measurement inputs synchronous to clk, 0.01 Hz and 0.01 % units.
`timescale 1ns/100ps
`include "frq_cfg.svh"
// Operation
// - Each stage compares selected frequency in hertz with its own pick-up level.
// - Three selectable references, evaluated on a 5 ms processing tick.
// - Four over and four under stages, each enable off after reset.
// - Forced status Normal/Start/Trip/Blocked applies only while forcing is permitted.
// - Enable and forcing settings stay untouched by setting-group switching.
// - Over stage picks up above level; under stage picks up below level.
// - Release needs a 20 mHz return past the pick-up level.
// - Stage parameters come from the active group; in-use flag defaults off.
// - Levels in 0.01 Hz steps; defaults 51 Hz over and 49 Hz under.
// - Under stages blocked below undervoltage threshold; zero threshold disables this.
// - Trip timing is definite time only.
// - Report stage condition and measured-to-set ratio in 0.001 steps.
// - Expose expected operating time and remaining time in 5 ms steps.
// - Blocking input sampled once per processing cycle and held for it.
// - Pick-up without blocking raises START and starts trip timing.
// - Pick-up with blocking raises BLOCKED and does no timing.
// - Blocking after START drops START and runs release handling.
// - Time-stamped ON/OFF events for Start, Trip, Blocked, per-event mask.
// - Resettable cumulative counters for START, TRIP and BLOCKED.
// - Keep twelve fault records with stamp, event, pre and fault frequency, group.
// - With delayed release, START holds for release time after pick-up drops.
module frq_prot #(
  parameter int TICK_CYCLES = `FRQ_TICK_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement and blocking
  input wire frq_pkg::frq_meas_type meas,
  // Stage outputs, 0-3 over, 4-7 under
  output logic [7:0] start,
  output logic [7:0] trip,
  output logic [7:0] blocked,
  // Event stream
  output logic ev_valid,
  output frq_pkg::frq_event_type ev
);
  import frq_pkg::*;
  // Configuration
  logic [1:0] ref_sel;
  logic force_perm, grp, rel_en, cnt_clr;
  logic [7:0] stg_en;
  logic [15:0] force_cfg;
  logic [5:0] evmask;
  logic [13:0] uv_lvl;
  frq_ticks_type rel_time;
  logic [3:0] psel_r, rec_sel;
  frq_param_type prm [16];
  // Processing
  logic [31:0] tdiv, stamp;
  logic tick, tick_d, tick_e, tick_f;
  frq_freq_type f_s;
  frq_freq_type hist [`FRQ_PRE_TICKS];
  logic blk_s, uv_blk;
  logic [7:0] st_v, tr_v, bl_v;
  frq_ticks_type rem_v [8];
  logic [15:0] cond, ratio;
  logic [25:0] ratio_num;
  // Events and records
  logic scan_on, cur, prv, hit;
  logic [4:0] scan_idx;
  logic [1:0] kind;
  logic [2:0] sidx;
  logic [7:0] rep [3];
  logic [15:0] cnt [3];
  logic [3:0] wp;
  logic [31:0] rec_time [`FRQ_NREC];
  logic [5:0] rec_code [`FRQ_NREC];
  logic [31:0] rec_freq [`FRQ_NREC];
  // APB
  logic acc, wr_en;
  logic [31:0] rdata;
  logic rhit;
  logic [3:0] pidx;

  assign acc = psel && penable && !pready;
  assign wr_en = psel && penable && pwrite && pready;
  assign pidx = {grp, psel_r[2:0]};

  // Processing tick
  always_ff @(posedge clk) begin
    if (rst) begin
      tdiv <= 32'h00000000;
      tick <= 1'b0;
      tick_d <= 1'b0;
      tick_e <= 1'b0;
      tick_f <= 1'b0;
      stamp <= 32'h00000000;
    end else if (ce) begin
      tick <= tdiv == 32'(TICK_CYCLES - 1);
      tdiv <= (tdiv == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tdiv + 32'h00000001;
      tick_d <= tick;
      tick_e <= tick_d;
      tick_f <= tick_e;
      if (tick)
        stamp <= stamp + 32'h00000001;
    end
  end

  // Input sampling once per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      f_s <= 16'h0000;
      blk_s <= 1'b0;
      uv_blk <= 1'b0;
      for (int i = 0; i < `FRQ_PRE_TICKS; i++)
        hist[i] <= 16'h0000;
    end else if (ce && tick) begin
      case (ref_sel)
        2'h1: f_s <= meas.f2;
        2'h2: f_s <= meas.f3;
        default: f_s <= meas.f1;
      endcase
      blk_s <= meas.block;
      uv_blk <= (uv_lvl != 14'h0000) && (meas.volt < {2'h0, uv_lvl});
      hist[0] <= f_s;
      for (int i = 1; i < `FRQ_PRE_TICKS; i++)
        hist[i] <= hist[i - 1];
    end
  end

  // Stages
  for (genvar i = 0; i < 8; i++) begin : g_stage
    frq_stage #(.UNDER(i >= 4)) u_stage (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .tick(tick_d),
      .active(stg_en[i] && prm[{grp, 3'(i)}].in_use),
      .force_on(force_perm),
      .force_val(frq_cond_type'(force_cfg[2*i+:2])),
      .prm(prm[{grp, 3'(i)}]),
      .rel_time(rel_time),
      .rel_en(rel_en),
      .freq(f_s),
      .uv_blk(uv_blk),
      .blk_in(blk_s),
      .start(st_v[i]),
      .trip(tr_v[i]),
      .blocked(bl_v[i]),
      .remain(rem_v[i])
    );
    assign cond[2*i+:2] = bl_v[i] ? FRQ_BLOCKED : tr_v[i] ? FRQ_TRIP :
                          st_v[i] ? FRQ_START : FRQ_NORMAL;
  end
  assign start = st_v;
  assign trip = tr_v;
  assign blocked = bl_v;

  // Ratio of selected stage
  assign ratio_num = {10'h000, f_s} * `FRQ_RATIO_SCALE;
  frq_div u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .go(tick_d),
    .num(ratio_num),
    .den(prm[pidx].level),
    .quo(ratio)
  );

  // Event scan after each processing cycle
  assign kind = scan_idx[4:3];
  assign sidx = scan_idx[2:0];
  always_comb begin
    case (kind)
      2'h0: cur = st_v[sidx];
      2'h1: cur = tr_v[sidx];
      default: cur = bl_v[sidx];
    endcase
    prv = rep[kind][sidx];
    hit = scan_on && (cur != prv);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scan_on <= 1'b0;
      scan_idx <= 5'h00;
      ev_valid <= 1'b0;
      ev <= '0;
      for (int k = 0; k < 3; k++)
        rep[k] <= 8'h00;
    end else if (ce) begin
      ev_valid <= 1'b0;
      if (tick_f) begin
        scan_on <= 1'b1;
        scan_idx <= 5'h00;
      end else if (scan_on) begin
        scan_on <= scan_idx != 5'h17;
        scan_idx <= scan_idx + 5'h01;
      end
      if (hit) begin
        rep[kind][sidx] <= cur;
        if (evmask[{kind, cur}]) begin
          ev_valid <= 1'b1;
          ev <= {stamp, sidx, kind, cur};
        end
      end
    end
  end

  // Cumulative counters, a clear and a count in the same cycle leave the counter at one
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 3; k++)
        cnt[k] <= 16'h0000;
    end else if (ce) begin
      for (int k = 0; k < 3; k++)
        if (hit && cur && kind == 2'(k))
          cnt[k] <= (cnt_clr ? 16'h0000 : cnt[k]) + 16'h0001;
        else if (cnt_clr)
          cnt[k] <= 16'h0000;
    end
  end

  // Fault record ring
  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= 4'h0;
      for (int n = 0; n < `FRQ_NREC; n++) begin
        rec_time[n] <= 32'h00000000;
        rec_code[n] <= 6'h00;
        rec_freq[n] <= 32'h00000000;
      end
    end else if (ce && hit && cur) begin
      rec_time[wp] <= stamp;
      rec_code[wp] <= {sidx, kind, grp};
      rec_freq[wp] <= {hist[`FRQ_PRE_TICKS - 1], f_s};
      wp <= (wp == 4'(`FRQ_NREC - 1)) ? 4'h0 : wp + 4'h1;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_sel <= `FRQ_REFSEL_RST;
      force_perm <= 1'b0;
      grp <= 1'b0;
      rel_en <= `FRQ_RELEN_RST;
      cnt_clr <= 1'b0;
      stg_en <= 8'h00;
      force_cfg <= 16'h0000;
      evmask <= `FRQ_EVMASK_RST;
      uv_lvl <= 14'h0000;
      rel_time <= 19'(`FRQ_REL_MS / `FRQ_TICK_MS);
      psel_r <= 4'h0;
      rec_sel <= 4'h0;
      for (int n = 0; n < 16; n++) begin
        prm[n].in_use <= 1'b0;
        prm[n].level <= (n % 8 < 4) ? `FRQ_OVER_RST : `FRQ_UNDER_RST;
        prm[n].delay <= 19'(`FRQ_DLY_MS / `FRQ_TICK_MS);
      end
    end else if (ce) begin
      cnt_clr <= wr_en && paddr == `FRQ_CTRL && pwdata[`FRQ_CTRL_CLR];
      if (wr_en) begin
        case (paddr)
          `FRQ_CTRL: begin
            ref_sel <= pwdata[1:0];
            force_perm <= pwdata[`FRQ_CTRL_FORCE];
            grp <= pwdata[`FRQ_CTRL_GROUP];
            rel_en <= pwdata[`FRQ_CTRL_RELEN];
          end
          `FRQ_STG_EN: stg_en <= pwdata[7:0];
          `FRQ_FORCE: force_cfg <= pwdata[15:0];
          `FRQ_EVMASK: evmask <= pwdata[5:0];
          `FRQ_UVLVL: uv_lvl <= pwdata[13:0];
          `FRQ_RELTIME: rel_time <= pwdata[18:0];
          `FRQ_PSEL: psel_r <= pwdata[3:0];
          `FRQ_PLEVEL: begin
            prm[psel_r].level <= pwdata[15:0];
            prm[psel_r].in_use <= pwdata[`FRQ_PLEVEL_INUSE];
          end
          `FRQ_PDELAY: prm[psel_r].delay <= pwdata[18:0];
          `FRQ_REC_SEL: rec_sel <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Register reads
  always_comb begin
    rdata = 32'h00000000;
    rhit = 1'b1;
    case (paddr)
      `FRQ_CTRL: rdata = {27'h0, rel_en, grp, force_perm, ref_sel};
      `FRQ_STG_EN: rdata = {24'h0, stg_en};
      `FRQ_FORCE: rdata = {16'h0, force_cfg};
      `FRQ_EVMASK: rdata = {26'h0, evmask};
      `FRQ_UVLVL: rdata = {18'h0, uv_lvl};
      `FRQ_RELTIME: rdata = {13'h0, rel_time};
      `FRQ_PSEL: rdata = {28'h0, psel_r};
      `FRQ_PLEVEL: rdata = {15'h0, prm[psel_r].in_use, prm[psel_r].level};
      `FRQ_PDELAY: rdata = {13'h0, prm[psel_r].delay};
      `FRQ_STATUS: rdata = {16'h0, cond};
      `FRQ_RATIO: rdata = {16'h0, ratio};
      `FRQ_EXPECT: rdata = {13'h0, prm[pidx].delay};
      `FRQ_REMAIN: rdata = {13'h0, rem_v[psel_r[2:0]]};
      `FRQ_CNT_S: rdata = {16'h0, cnt[0]};
      `FRQ_CNT_T: rdata = {16'h0, cnt[1]};
      `FRQ_CNT_B: rdata = {16'h0, cnt[2]};
      `FRQ_REC_SEL: rdata = {24'h0, wp, rec_sel};
      `FRQ_REC_TIME: rdata = (rec_sel < 4'(`FRQ_NREC)) ? rec_time[rec_sel] : 32'h0;
      `FRQ_REC_INFO: rdata = (rec_sel < 4'(`FRQ_NREC)) ? {26'h0, rec_code[rec_sel]} : 32'h0;
      `FRQ_REC_FREQ: rdata = (rec_sel < 4'(`FRQ_NREC)) ? rec_freq[rec_sel] : 32'h0;
      default: rhit = 1'b0;
    endcase
  end

  // APB answer one wait state after setup
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= acc;
      if (acc) begin
        prdata <= pwrite ? 32'h00000000 : rdata;
        pslverr <= !rhit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// >>> dv/frq_prot_chk.sv
// Concurrent checks on the frequency protection top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module frq_prot_chk (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Results
  input wire logic [7:0] start,
  input wire logic [7:0] trip,
  input wire logic [7:0] blocked,
  input wire logic ev_valid,
  input wire frq_pkg::frq_event_type ev
);
  import frq_pkg::*;
  // Outputs as the event scan saw them one cycle before the event
  logic [7:0] start_q, trip_q;
  always_ff @(posedge clk) begin
    start_q <= start;
    trip_q <= trip;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late after access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_idle: assert property (!psel |-> !pready)
    else $error("pready without a selected transfer");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  chk_start_block: assert property ((start & blocked) == 8'h00)
    else $error("start and blocked together");
  chk_trip_block: assert property ((trip & blocked) == 8'h00)
    else $error("trip and blocked together");
  chk_out_hold: assert property ($changed({start, trip}) |=> $stable({start, trip})[*2])
    else $error("outputs moved between processing cycles");
  chk_ev_start: assert property (ev_valid && ev.kind == 2'd0 |-> start_q[ev.stage] == ev.on)
    else $error("start event disagrees with output");
  chk_ev_trip: assert property (ev_valid && ev.kind == 2'd1 |-> trip_q[ev.stage] == ev.on)
    else $error("trip event disagrees with output");
  chk_ev_kind: assert property (ev_valid |-> ev.kind != 2'd3)
    else $error("event kind out of range");
  cover property (ev_valid && ev.on);
  cover property (|trip);
  cover property (|blocked);
  cover property (pslverr);
endmodule

bind frq_prot frq_prot_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start(start),
  .trip(trip), .blocked(blocked), .ev_valid(ev_valid), .ev(ev));

// >>> dv/frq_fe.sv
// Frequency measurement front end and blocking source model.
// Assumes the bench sets requested values; all three references differ.
`timescale 1ns/100ps
module frq_fe (
  // Clock
  input wire logic clk,
  // Requested values
  input wire frq_pkg::frq_freq_type f_req,
  input wire logic [15:0] v_req,
  input wire logic blk_req,
  // Measurement bundle
  output frq_pkg::frq_meas_type meas
);
  import frq_pkg::*;
  always_ff @(posedge clk) begin
    meas.f1 <= f_req;
    meas.f2 <= f_req + 16'h0064;
    meas.f3 <= f_req - 16'h0064;
    meas.volt <= v_req;
    // Bench raises block at least one tick ahead of any delay expiry
    meas.block <= blk_req;
  end
endmodule

// >>> dv/frequency_protection_stages_tb.sv
// Self-checking bench for the frequency protection block.
// Assumes a shortened processing tick of 64 clocks.
`timescale 1ns/100ps
`include "frq_cfg.svh"
module frequency_protection_stages_tb;
  import frq_pkg::*;
  localparam int TC = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ev_valid;
  logic [7:0] start;
  logic [7:0] trip;
  logic [7:0] blocked;
  frq_event_type ev;
  frq_event_type ev_last = '0;
  int ev_n = 0;
  frq_meas_type meas;
  frq_freq_type f_req = 16'h1388;
  logic [15:0] v_req = 16'h2710;
  logic blk_req = 1'b0;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  frq_fe u_fe (.clk(clk), .f_req(f_req), .v_req(v_req), .blk_req(blk_req), .meas(meas));
  frq_prot #(.TICK_CYCLES(TC)) dut (.clk(clk), .rst(rst), .ce(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .start(start), .trip(trip),
    .blocked(blocked), .ev_valid(ev_valid), .ev(ev));
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ev_valid === 1'b1) begin
      ev_last <= ev;
      ev_n <= ev_n + 1;
    end
    if (cyc == 60000) begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      end_of_test();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic r(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge clk);
  endtask
  task automatic reset_values();
    r(`FRQ_CTRL);
    chk(rd, 32'h10);
    r(`FRQ_STG_EN);
    chk(rd, 32'h0);
    r(`FRQ_EVMASK);
    chk(rd, 32'h3f);
    r(`FRQ_PLEVEL);
    chk(rd, 32'h13ec);
    w(`FRQ_PSEL, 32'h4);
    r(`FRQ_PLEVEL);
    chk(rd, 32'h1324);
    r(8'h50);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic over_trip();
    w(`FRQ_CTRL, 32'h0);
    w(`FRQ_PSEL, 32'h0);
    w(`FRQ_PLEVEL, 32'h113ec);
    w(`FRQ_PDELAY, 32'h3);
    w(`FRQ_STG_EN, 32'h1);
    f_req <= 16'h13ed;
    ticks(2);
    chk({24'h0, start}, 32'h1);
    chk({24'h0, trip}, 32'h0);
    r(`FRQ_EXPECT);
    chk(rd, 32'h3);
    ticks(3);
    chk({24'h0, trip}, 32'h1);
    f_req <= 16'h13eb;
    ticks(2);
    chk({24'h0, start}, 32'h1);
    f_req <= 16'h13ea;
    ticks(2);
    chk({16'h0, start, trip}, 32'h0);
    f_req <= 16'h13ec;
    ticks(2);
    chk({24'h0, start}, 32'h0);
    r(`FRQ_RATIO);
    chk(rd, 32'h3e8);
    w(`FRQ_CTRL, 32'h1);
    ticks(2);
    r(`FRQ_RATIO);
    chk(rd, 32'h3fb);
    w(`FRQ_CTRL, 32'h0);
    f_req <= 16'h1388;
    ticks(2);
  endtask
  task automatic block_seq();
    blk_req <= 1'b1;
    f_req <= 16'h13ed;
    ticks(2);
    chk({16'h0, blocked, start}, 32'h100);
    blk_req <= 1'b0;
    ticks(2);
    chk({16'h0, blocked, start}, 32'h1);
    blk_req <= 1'b1;
    ticks(2);
    chk({16'h0, start, trip}, 32'h0);
    blk_req <= 1'b0;
    f_req <= 16'h1388;
    ticks(2);
  endtask
  task automatic under_uv();
    w(`FRQ_CTRL, 32'h20);
    r(`FRQ_CNT_S);
    chk(rd, 32'h0);
    w(`FRQ_PSEL, 32'h4);
    w(`FRQ_PLEVEL, 32'h11324);
    w(`FRQ_STG_EN, 32'h11);
    w(`FRQ_UVLVL, 32'h1388);
    v_req <= 16'h0fa0;
    f_req <= 16'h1323;
    ticks(2);
    chk({24'h0, start}, 32'h0);
    v_req <= 16'h1770;
    ticks(2);
    chk({24'h0, start}, 32'h10);
    r(`FRQ_CNT_S);
    chk(rd, 32'h1);
    w(`FRQ_CTRL, 32'h8);
    ticks(2);
    chk({24'h0, start}, 32'h0);
    r(`FRQ_STG_EN);
    chk(rd, 32'h11);
    f_req <= 16'h1388;
    w(`FRQ_CTRL, 32'h0);
    ticks(2);
  endtask
  task automatic release_seq();
    int n0;
    n0 = ev_n;
    w(`FRQ_EVMASK, 32'h2);
    w(`FRQ_RELTIME, 32'h2);
    w(`FRQ_CTRL, 32'h10);
    ticks(3);
    f_req <= 16'h13ed;
    ticks(2);
    chk({24'h0, start}, 32'h1);
    f_req <= 16'h1388;
    ticks(2);
    chk({24'h0, start}, 32'h1);
    ticks(2);
    chk({24'h0, start}, 32'h0);
    chk(32'(ev_n - n0), 32'h1);
    chk({26'h0, ev_last.stage, ev_last.kind, ev_last.on}, 32'h1);
    r(`FRQ_CNT_S);
    chk(rd, 32'h2);
    r(`FRQ_REC_SEL);
    w(`FRQ_REC_SEL, (rd[7:4] == 4'h0) ? 32'hb : 32'(rd[7:4] - 4'h1));
    r(`FRQ_REC_FREQ);
    chk(rd, 32'h138813ed);
  endtask
  task automatic force_seq();
    w(`FRQ_FORCE, 32'h8);
    ticks(1);
    chk({24'h0, trip}, 32'h0);
    w(`FRQ_CTRL, 32'h4);
    for (int k = 1; k < 4; k++) begin
      w(`FRQ_FORCE, 32'(k) << 2);
      repeat (2) @(posedge clk);
      chk({29'h0, blocked[1], trip[1], start[1]}, 32'(1) << (k - 1));
    end
    w(`FRQ_FORCE, 32'h0);
    repeat (2) @(posedge clk);
    chk({8'h0, start, trip, blocked}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    over_trip();
    block_seq();
    under_uv();
    release_seq();
    force_seq();
    end_of_test();
  end
endmodule
